//--- src/rmt_pkg.sv
package rmt_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_CORR   = 8'h0d;
  localparam logic [7:0] ADDR_MASK   = 8'h0f;
  localparam logic [7:0] ADDR_NRT_HI = 8'h10;
  localparam logic [7:0] ADDR_NRT_LO = 8'h11;
  localparam logic [7:0] ADDR_TCTRL  = 8'h12;
  localparam logic [7:0] ADDR_IRQ_ST = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MK = 8'h19;
  localparam logic [7:0] ADDR_MODE   = 8'h1a;
  localparam logic [7:0] ADDR_RUN_ST = 8'h1b;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_CORR  = 8'h00;
  localparam logic [7:0] RST_MASK  = 8'h08;
  localparam logic [7:0] RST_NRT   = 8'h00;
  localparam logic [3:0] RST_TCTRL = 4'h0;
  localparam logic [2:0] RST_IRQ   = 3'h0;
  localparam logic [2:0] RST_MODE  = 3'h0;
  // ==========================================================
  // field positions
  localparam int CORR_SUBC_BIT = 0;
  localparam int CORR_REL_BIT  = 1;
  localparam int IRQ_NRT_BIT   = 0;
  localparam int IRQ_MASK_BIT  = 1;
  localparam int IRQ_SLEEP_BIT = 2;
  localparam int MODE_NFC_BIT  = 0;
  localparam int MODE_AP_BIT   = 1;
  localparam int MODE_LONG_BIT = 2;
  // ==========================================================
  // carrier periods per count unit
  localparam logic [12:0] MASK_UNIT_SHORT = 13'd64;
  localparam logic [12:0] MASK_UNIT_LONG  = 13'd512;
  localparam logic [12:0] NRT_UNIT_SHORT  = 13'd64;
  localparam logic [12:0] NRT_UNIT_LONG   = 13'd4096;
  // ==========================================================
  // correlator timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int SLEEP_IDLE_NS   = 18000;
  localparam int REL_SHORT_NS    = 18000;
  localparam int REL_LONG_NS     = 42000;
  localparam int SLEEP_IDLE_CYC  = (SLEEP_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REL_SHORT_CYC   = (REL_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REL_LONG_CYC    = (REL_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================
  // types
  typedef struct packed {
    logic mrt_step;
    logic nrt_peer_sel;
    logic nrt_emv;
    logic nrt_step;
  } rmt_tctrl_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rmt_bus_t;
  typedef enum logic [1:0] {NRT_IDLE, NRT_WAIT, NRT_RUN} rmt_nrt_state_t;
  typedef enum logic {CORR_AWAKE, CORR_SLEEP} rmt_corr_state_t;
endpackage : rmt_pkg

//--- src/rmt_rx_timers.sv
// Functional notes
// (R1) After every end of transmission the receiver output is masked for the programmed mask count.
// (R2) With mask step clear one mask unit is 64 carrier periods.
// (R3) With mask step set one mask unit is 512 carrier periods.
// (R4) The 16-bit timeout count is split as upper byte at 10h and lower byte at 11h.
// (R5) A timeout that expires before any response raises the no-response interrupt.
// (R6) One timeout unit is 64 carrier periods, or 4096 with timeout step set.
// (R7) In NFC mode the timeout timer starts only once an external field is seen.
// (R8) In active peer mode the timeout timer starts by itself when the transmitter turns off.
// (R9) A timeout count of all zeros never starts the timeout timer.
// (R10) The start-timer command resets the timeout timer and counts again.
// (R11) The correlator sleeps after 18 us without pulse and wakes by timer or only by receiver on.
// (R12) Timer wake takes 18 us for A, B and F424, and 42 us for vicinity stream and F212.
// (R13) Software sets the stream select bit only for 424 kHz subcarrier stream mode.
// (R14) Mask step select is timer control bit 3.
// (R15) Timeout step select is timer control bit 0.
// (R16) In active peer mode bit 2 picks start at own transmit end or at peer field on.
// (R17) Both timers tick on the carrier and sample their setup at start.
//
// Chosen here: the plain strobed port.
module rmt_rx_timers import rmt_pkg::*; #(
  parameter int SLEEP_CYC     = SLEEP_IDLE_CYC,
  parameter int REL_SHORT     = REL_SHORT_CYC,
  parameter int REL_LONG      = REL_LONG_CYC
) (
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       nrst_in,
  // register port
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rd_data_out,
  // carrier and sequencer events
  input  wire logic       carrier_tick_in,
  input  wire logic       tx_end_in,
  input  wire logic       ext_field_in,
  input  wire logic       peer_field_on_in,
  input  wire logic       rx_resp_in,
  input  wire logic       start_nrt_cmd_in,
  // receiver and correlator
  input  wire logic       rx_data_in,
  input  wire logic       rx_on_in,
  input  wire logic       corr_pulse_in,
  output logic            rx_data_out,
  output logic            corr_sleep_out,
  output logic            subcarrier_stream_out,
  output logic            sleep_release_select_out,
  // status
  output logic            mask_active_out,
  output logic            nrt_running_out,
  output logic            irq_out
);
  if (SLEEP_CYC < 2 || REL_SHORT < 2 || REL_LONG < 2
      || SLEEP_CYC > 65536 || REL_SHORT > 65535 || REL_LONG > 65535) begin : g_chk
    $error("rmt_rx_timers: cycle counts out of range");
  end

  rmt_bus_t        bus;
  rmt_tctrl_t      tctrl_r;
  logic [1:0]      corr_r;
  logic [7:0]      mask_time_r;
  logic [7:0]      nrt_hi_r;
  logic [7:0]      nrt_lo_r;
  logic [2:0]      irq_st_r;
  logic [2:0]      irq_mk_r;
  logic [2:0]      mode_r;
  logic [2:0]      irq_set;
  logic [15:0]     nrt_val;
  assign bus     = '{wr: wr_in, rd: rd_in, addr: addr_in, wdata: wdata_in};
  assign nrt_val = {nrt_hi_r, nrt_lo_r}; // see (R4)

  // ==========================================================
  // register writes
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      corr_r      <= RST_CORR[1:0];
      mask_time_r <= RST_MASK;
      nrt_hi_r    <= RST_NRT;
      nrt_lo_r    <= RST_NRT;
      tctrl_r     <= RST_TCTRL;
      irq_mk_r    <= RST_IRQ;
      mode_r      <= RST_MODE;
    end else if (bus.wr) begin
      case (bus.addr)
        ADDR_CORR:   corr_r      <= bus.wdata[1:0];
        ADDR_MASK:   mask_time_r <= bus.wdata;
        ADDR_NRT_HI: nrt_hi_r    <= bus.wdata; // see (R4)
        ADDR_NRT_LO: nrt_lo_r    <= bus.wdata; // see (R4)
        ADDR_TCTRL:  tctrl_r     <= bus.wdata[3:0]; // see (R14) see (R15) see (R16)
        ADDR_IRQ_MK: irq_mk_r    <= bus.wdata[2:0];
        ADDR_MODE:   mode_r      <= bus.wdata[2:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // sticky status: a set in the clearing cycle survives
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_st_r <= RST_IRQ;
    end else if (bus.wr && bus.addr == ADDR_IRQ_ST) begin
      irq_st_r <= (irq_st_r & ~bus.wdata[2:0]) | irq_set;
    end else begin
      irq_st_r <= irq_st_r | irq_set;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_st_r & irq_mk_r);
    end
  end

  // ==========================================================
  // mask receive timer
  logic            mask_busy_r;
  logic [7:0]      mask_cnt_r;
  logic [11:0]     mask_pre_r;
  logic            mask_step_r;
  logic            mask_done;
  logic [11:0]     mask_last;
  assign mask_last = mask_step_r ? 12'(MASK_UNIT_LONG - 13'd1) : 12'(MASK_UNIT_SHORT - 13'd1); // see (R2) see (R3)
  assign mask_done = mask_busy_r && carrier_tick_in && mask_pre_r == mask_last
                     && mask_cnt_r == 8'd1;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mask_busy_r <= 1'b0;
      mask_cnt_r  <= 8'h00;
      mask_pre_r  <= 12'h000;
      mask_step_r <= 1'b0;
    end else if (tx_end_in && mask_time_r != 8'h00) begin
      // setup is latched here so later writes cannot stretch the window
      mask_busy_r <= 1'b1; // see (R1) see (R17)
      mask_cnt_r  <= mask_time_r;
      mask_pre_r  <= 12'h000;
      mask_step_r <= tctrl_r.mrt_step; // see (R14)
    end else if (mask_busy_r && carrier_tick_in) begin // see (R17)
      if (mask_pre_r == mask_last) begin
        mask_pre_r <= 12'h000;
        mask_cnt_r <= mask_cnt_r - 8'd1;
        if (mask_cnt_r == 8'd1) begin
          mask_busy_r <= 1'b0;
        end
      end else begin
        mask_pre_r <= mask_pre_r + 12'd1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_data_out <= 1'b0;
    end else begin
      rx_data_out <= mask_busy_r ? 1'b0 : rx_data_in; // see (R1)
    end
  end

  // ==========================================================
  // no-response timer
  rmt_nrt_state_t  nrt_st_r;
  logic [15:0]     nrt_cnt_r;
  logic [11:0]     nrt_pre_r;
  logic            nrt_step_r;
  logic            nrt_trig;
  logic            nrt_go;
  logic            nrt_expire;
  logic            resp_seen;
  logic [11:0]     nrt_last;
  assign resp_seen  = rx_resp_in && !mask_busy_r;
  assign nrt_last   = nrt_step_r ? 12'(NRT_UNIT_LONG - 13'd1) : 12'(NRT_UNIT_SHORT - 13'd1); // see (R6)
  assign nrt_expire = nrt_st_r == NRT_RUN && carrier_tick_in && nrt_pre_r == nrt_last
                      && nrt_cnt_r == 16'd1;

  always_comb begin
    if (mode_r[MODE_AP_BIT]) begin
      nrt_trig = tctrl_r.nrt_peer_sel ? peer_field_on_in : 1'b1; // see (R8) see (R16)
    end else if (mode_r[MODE_NFC_BIT]) begin
      nrt_trig = ext_field_in; // see (R7)
    end else begin
      nrt_trig = 1'b1;
    end
  end
  assign nrt_go = nrt_val != 16'h0000; // see (R9)

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      nrt_st_r   <= NRT_IDLE;
      nrt_cnt_r  <= 16'h0000;
      nrt_pre_r  <= 12'h000;
      nrt_step_r <= 1'b0;
    end else if (start_nrt_cmd_in || (nrt_go && nrt_trig
                 && (tx_end_in || nrt_st_r == NRT_WAIT))) begin
      nrt_st_r   <= nrt_go ? NRT_RUN : NRT_IDLE; // see (R10) see (R9)
      nrt_cnt_r  <= nrt_val;
      nrt_pre_r  <= 12'h000;
      nrt_step_r <= tctrl_r.nrt_step; // see (R15) see (R17)
    end else if (tx_end_in) begin
      nrt_st_r <= nrt_go ? NRT_WAIT : NRT_IDLE; // see (R7)
    end else begin
      case (nrt_st_r)
        NRT_RUN: begin
          if (resp_seen) begin
            nrt_st_r <= NRT_IDLE;
          end else if (carrier_tick_in) begin
            if (nrt_pre_r == nrt_last) begin
              nrt_pre_r <= 12'h000;
              nrt_cnt_r <= nrt_cnt_r - 16'd1;
              if (nrt_cnt_r == 16'd1) begin
                nrt_st_r <= NRT_IDLE; // see (R5)
              end
            end else begin
              nrt_pre_r <= nrt_pre_r + 12'd1;
            end
          end
        end
        NRT_WAIT: begin
          if (resp_seen) begin
            nrt_st_r <= NRT_IDLE;
          end
        end
        NRT_IDLE: ;
        default:  nrt_st_r <= NRT_IDLE;
      endcase
    end
  end

  // ==========================================================
  // correlator sleep
  rmt_corr_state_t corr_st_r;
  logic [15:0]     corr_cnt_r;
  logic            rx_on_q;
  logic            sleep_enter;
  logic            sleep_wake;
  logic [15:0]     rel_cyc;
  assign rel_cyc     = mode_r[MODE_LONG_BIT] ? 16'(REL_LONG) : 16'(REL_SHORT); // see (R12)
  assign sleep_enter = corr_st_r == CORR_AWAKE && !corr_pulse_in && corr_cnt_r == 16'(SLEEP_CYC - 1);
  assign sleep_wake  = corr_st_r == CORR_SLEEP && (corr_r[CORR_REL_BIT] ? (rx_on_in && !rx_on_q)
                       : corr_cnt_r == rel_cyc - 16'd1);

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_on_q <= 1'b0;
    end else begin
      rx_on_q <= rx_on_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      corr_st_r  <= CORR_AWAKE;
      corr_cnt_r <= 16'h0000;
    end else begin
      case (corr_st_r)
        CORR_AWAKE: begin
          if (corr_pulse_in) begin
            corr_cnt_r <= 16'h0000;
          end else if (sleep_enter) begin
            corr_st_r  <= CORR_SLEEP; // see (R11)
            corr_cnt_r <= 16'h0000;
          end else begin
            corr_cnt_r <= corr_cnt_r + 16'd1;
          end
        end
        CORR_SLEEP: begin
          if (sleep_wake) begin
            corr_st_r  <= CORR_AWAKE; // see (R11) see (R12)
            corr_cnt_r <= 16'h0000;
          end else if (!corr_r[CORR_REL_BIT]) begin
            corr_cnt_r <= corr_cnt_r + 16'd1;
          end
        end
        default: corr_st_r <= CORR_AWAKE;
      endcase
    end
  end

  assign irq_set = {sleep_enter, mask_done, nrt_expire}; // see (R5)

  // ==========================================================
  // status outputs and read port
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mask_active_out          <= 1'b0;
      nrt_running_out          <= 1'b0;
      corr_sleep_out           <= 1'b0;
      subcarrier_stream_out    <= 1'b0;
      sleep_release_select_out <= 1'b0;
    end else begin
      mask_active_out          <= mask_busy_r;
      nrt_running_out          <= nrt_st_r == NRT_RUN;
      corr_sleep_out           <= corr_st_r == CORR_SLEEP;
      subcarrier_stream_out    <= corr_r[CORR_SUBC_BIT]; // see (R13)
      sleep_release_select_out <= corr_r[CORR_REL_BIT];
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_data_out <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        ADDR_CORR:   rd_data_out <= {6'h00, corr_r};
        ADDR_MASK:   rd_data_out <= mask_time_r;
        ADDR_NRT_HI: rd_data_out <= nrt_hi_r;
        ADDR_NRT_LO: rd_data_out <= nrt_lo_r;
        ADDR_TCTRL:  rd_data_out <= {4'h0, tctrl_r};
        ADDR_IRQ_ST: rd_data_out <= {5'h00, irq_st_r};
        ADDR_IRQ_MK: rd_data_out <= {5'h00, irq_mk_r};
        ADDR_MODE:   rd_data_out <= {5'h00, mode_r};
        ADDR_RUN_ST: rd_data_out <= {4'h0, corr_st_r == CORR_SLEEP, nrt_st_r == NRT_WAIT,
                                     nrt_st_r == NRT_RUN, mask_busy_r};
        default:     rd_data_out <= 8'h00;
      endcase
    end else begin
      rd_data_out <= 8'h00;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  a_mask_start: assert property (tx_end_in && mask_time_r != 8'h00 |=> mask_busy_r) // see (R1)
    else $error("mask timer did not start");
  a_mask_blank: assert property (mask_busy_r |=> !rx_data_out) // see (R1)
    else $error("receiver output not masked");
  a_mask_unit: assert property (mask_busy_r && !mask_step_r |-> mask_pre_r < 12'(MASK_UNIT_SHORT)) // see (R2)
    else $error("mask unit wrong");
  a_mask_step: assert property (tx_end_in && mask_time_r != 8'h00 // see (R3)
    |=> mask_step_r == $past(tctrl_r.mrt_step))
    else $error("mask step not sampled");
  a_nrt_zero: assert property (nrt_val == 16'h0000 && nrt_st_r != NRT_RUN |=> nrt_st_r != NRT_RUN) // see (R9)
    else $error("timer ran with zero count");
  a_nrt_cmd: assert property (start_nrt_cmd_in && nrt_go |=> nrt_st_r == NRT_RUN
    && nrt_cnt_r == $past(nrt_val) && nrt_pre_r == 12'h000) // see (R10)
    else $error("start command did not restart");
  a_nrt_irq: assert property (nrt_expire |=> irq_st_r[IRQ_NRT_BIT] && nrt_st_r == NRT_IDLE) // see (R5)
    else $error("timeout not flagged");
  a_nrt_nfc: assert property (mode_r == 3'h1 && !ext_field_in && tx_end_in && !start_nrt_cmd_in
    |=> nrt_st_r != NRT_RUN) // see (R7)
    else $error("nfc start without field");
  a_nrt_ap: assert property (mode_r[MODE_AP_BIT] && !tctrl_r.nrt_peer_sel && tx_end_in && nrt_go
    |=> nrt_st_r == NRT_RUN) // see (R8)
    else $error("active peer start missed");
  a_sleep_idle: assert property (sleep_enter |=> corr_st_r == CORR_SLEEP ##1 corr_sleep_out) // see (R11)
    else $error("sleep entry wrong");
  a_sleep_rel: assert property (corr_st_r == CORR_AWAKE ##1 corr_st_r == CORR_SLEEP && !corr_r[CORR_REL_BIT]
    && !mode_r[MODE_LONG_BIT] |-> (corr_st_r == CORR_SLEEP) [*8]) // see (R12)
    else $error("sleep release too early");
  a_irq_level: assert property (|(irq_st_r & irq_mk_r) |=> irq_out)
    else $error("interrupt output missing");

  c_mask_run: cover property (tx_end_in ##1 mask_busy_r ##[1:1000] !mask_busy_r);
  c_nrt_exp:  cover property (nrt_expire);
  c_nrt_resp: cover property (nrt_st_r == NRT_RUN ##1 resp_seen);
  c_sleep:    cover property (sleep_enter ##[1:1000] sleep_wake);
endmodule : rmt_rx_timers

//--- tb/rmt_seq_model.sv
module rmt_seq_model #(
  parameter int TICK_DIV = 2
) (
  // clock and reset
  input  wire logic ref_clk_in,
  input  wire logic nrst_in,
  // sequencer events
  output logic      carrier_tick_out,
  output logic      tx_end_out,
  output logic      peer_field_on_out,
  output logic      rx_resp_out,
  output logic      start_nrt_cmd_out,
  output logic      ext_field_out,
  // receiver side
  output logic      rx_data_out,
  output logic      rx_on_out,
  output logic      corr_pulse_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ev_r        = 4'h0;
  int         div_r       = 0;
  logic [1:0] ph_r        = 2'h0;
  logic       corr_en_r   = 1'b1;
  logic       ext_field_r = 1'b0;
  logic       rx_on_r     = 1'b0;
  // ==========================================================
  // carrier ticks and receiver activity
  always @(posedge ref_clk_in) begin
    div_r <= (div_r == TICK_DIV - 1) ? 0 : div_r + 1;
    ph_r  <= ph_r + 2'h1;
  end
  assign carrier_tick_out  = nrst_in && (div_r == 0);
  // receiver output toggles every cycle so any leak through the mask shows
  assign rx_data_out       = ph_r[0];
  assign corr_pulse_out    = corr_en_r && (ph_r == 2'h0);
  assign ext_field_out     = ext_field_r;
  assign rx_on_out         = rx_on_r;
  assign tx_end_out        = ev_r[0];
  assign peer_field_on_out = ev_r[1];
  assign rx_resp_out       = ev_r[2];
  assign start_nrt_cmd_out = ev_r[3];
  // ==========================================================
  // one-cycle event pulse, launched after an edge
  task automatic fire(input int which);
    @(posedge ref_clk_in);
    ev_r[which] <= 1'b1;
    @(posedge ref_clk_in);
    ev_r[which] <= 1'b0;
  endtask : fire
endmodule : rmt_seq_model

//--- tb/rx_mask_and_response_timers_bench.sv
module rx_mask_and_response_timers_bench import rmt_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TDIV = 2;
  localparam int RSH  = 20;
  localparam int RLG  = 40;
  localparam int EV_TX = 0;
  localparam int EV_PEER = 1;
  localparam int EV_RESP = 2;
  localparam int EV_CMD = 3;
  logic       ref_clk_in = 1'b0;
  logic       nrst_in    = 1'b0;
  logic [7:0] addr       = 8'h00;
  logic [7:0] wdata      = 8'h00;
  logic       wr         = 1'b0;
  logic       rd         = 1'b0;
  logic [7:0] rd_data;
  logic       tick, tx_end, peer_on, resp, cmd, ext_field, rxd_in, rx_on, corr_pulse;
  logic       rxd_out, corr_sleep, subc, rel_sel, mask_act, nrt_run, irq;
  int         mismatches  = 0;
  int         checks_done = 0;
  int         cyc         = 0;
  always #5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) cyc <= cyc + 1;
  // short correlator counts keep the sleep scenarios brief
  rmt_rx_timers #(.SLEEP_CYC(20), .REL_SHORT(RSH), .REL_LONG(RLG)) dut_u (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rd_data_out(rd_data), .carrier_tick_in(tick), .tx_end_in(tx_end), .ext_field_in(ext_field),
    .peer_field_on_in(peer_on), .rx_resp_in(resp), .start_nrt_cmd_in(cmd), .rx_data_in(rxd_in),
    .rx_on_in(rx_on), .corr_pulse_in(corr_pulse), .rx_data_out(rxd_out), .corr_sleep_out(corr_sleep),
    .subcarrier_stream_out(subc), .sleep_release_select_out(rel_sel), .mask_active_out(mask_act),
    .nrt_running_out(nrt_run), .irq_out(irq));
  rmt_seq_model #(.TICK_DIV(TDIV)) seq_u (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .carrier_tick_out(tick), .tx_end_out(tx_end),
    .peer_field_on_out(peer_on), .rx_resp_out(resp), .start_nrt_cmd_out(cmd), .ext_field_out(ext_field),
    .rx_data_out(rxd_in), .rx_on_out(rx_on), .corr_pulse_out(corr_pulse));
  // ==========================================================
  // checking and waiting
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // carrier phase at the start of a count allows a few cycles of slack
  task automatic near(input string what, input int exp, input int got);
    checks_done++;
    if (got < exp - 3 || got > exp + 3) begin
      mismatches++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask : near
  function automatic logic probe(input int sel);
    case (sel)
      0: return mask_act;
      1: return nrt_run;
      2: return corr_sleep;
      default: return irq;
    endcase
  endfunction : probe
  task automatic wait_lvl(input int sel, input logic lvl, input int bound);
    int n = 0;
    @(negedge ref_clk_in);
    while (probe(sel) !== lvl) begin
      @(negedge ref_clk_in);
      n++;
      if (n > bound) begin
        mismatches++;
        $display("MISMATCH wait on %0d expected %b seen timeout", sel, lvl);
        give_verdict();
      end
    end
  endtask : wait_lvl
  task automatic hold(input int sel, input logic lvl, input int cycles, input string what);
    logic bad = 1'b0;
    repeat (cycles) begin
      @(negedge ref_clk_in);
      if (probe(sel) !== lvl) bad = 1'b1;
    end
    chk(what, 8'h00, {7'h0, bad});
  endtask : hold
  // ==========================================================
  // register port
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk_in);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk_in);
    rd   <= 1'b0;
    @(negedge ref_clk_in);
    d = rd_data;
  endtask : rd_reg
  task automatic set_nrt(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] ctl);
    wr_reg(ADDR_NRT_HI, hi);
    wr_reg(ADDR_NRT_LO, lo);
    wr_reg(ADDR_TCTRL, ctl);
  endtask : set_nrt
  task automatic stop_nrt();
    set_nrt(8'h00, 8'h00, 8'h00);
    seq_u.fire(EV_CMD);
    wait_lvl(1, 1'b0, 4);
  endtask : stop_nrt
  // ==========================================================
  // scenarios
  task automatic s_reset();
    logic [7:0] a_t [9] = '{ADDR_CORR, ADDR_MASK, ADDR_NRT_HI, ADDR_NRT_LO, ADDR_TCTRL, ADDR_IRQ_ST,
                            ADDR_IRQ_MK, ADDR_MODE, 8'h3c};
    logic [7:0] e_t [9] = '{RST_CORR, RST_MASK, RST_NRT, RST_NRT, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] d;
    wr_reg(ADDR_RUN_ST, 8'hff);
    for (int i = 0; i < 9; i++) begin
      rd_reg(a_t[i], d);
      chk("reset value", e_t[i], d);
    end
    rd_reg(ADDR_RUN_ST, d);
    chk("read-only status", 8'h00, d);
    wr_reg(ADDR_NRT_HI, 8'ha5);
    wr_reg(ADDR_NRT_LO, 8'h5a);
    rd_reg(ADDR_NRT_HI, d);
    chk("timeout high byte", 8'ha5, d);
    rd_reg(ADDR_NRT_LO, d);
    chk("timeout low byte", 8'h5a, d);
  endtask : s_reset
  task automatic s_mask(input logic [7:0] ctl, input logic [7:0] cnt, input int exp);
    int t0;
    logic [7:0] d;
    wr_reg(ADDR_TCTRL, ctl);
    wr_reg(ADDR_MASK, cnt);
    wr_reg(ADDR_IRQ_ST, 8'h02);
    seq_u.fire(EV_TX);
    wait_lvl(0, 1'b1, 4);
    t0 = cyc;
    wr_reg(ADDR_TCTRL, 8'h00);
    repeat (2) begin
      @(negedge ref_clk_in);
      chk("masked rx", 8'h00, {7'h0, rxd_out});
    end
    wait_lvl(0, 1'b0, exp + 8);
    near("mask time", exp, cyc - t0);
    repeat (2) @(negedge ref_clk_in);
    chk("rx after mask", {7'h0, ~rxd_in}, {7'h0, rxd_out});
    rd_reg(ADDR_IRQ_ST, d);
    chk("mask end status", 8'h02, d & 8'h02);
  endtask : s_mask
  task automatic s_nrt(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] ctl, input int exp);
    int t0;
    logic [7:0] d;
    set_nrt(hi, lo, ctl);
    seq_u.fire(EV_CMD);
    wait_lvl(1, 1'b1, 4);
    t0 = cyc;
    wait_lvl(1, 1'b0, exp + 8);
    near("timeout time", exp, cyc - t0);
    rd_reg(ADDR_IRQ_ST, d);
    chk("timeout status", 8'h01, d & 8'h01);
  endtask : s_nrt
  task automatic s_irq();
    chk("irq while masked", 8'h00, {7'h0, irq});
    wr_reg(ADDR_IRQ_MK, 8'h01);
    wait_lvl(3, 1'b1, 3);
    chk("irq unmasked", 8'h01, {7'h0, irq});
    wr_reg(ADDR_IRQ_ST, 8'h01);
    wait_lvl(3, 1'b0, 3);
    chk("irq cleared", 8'h00, {7'h0, irq});
  endtask : s_irq
  task automatic s_zero_restart();
    int t0;
    set_nrt(8'h00, 8'h00, 8'h00);
    seq_u.fire(EV_CMD);
    hold(1, 1'b0, 20, "zero count run");
    set_nrt(8'h00, 8'h02, 8'h00);
    seq_u.fire(EV_CMD);
    wait_lvl(1, 1'b1, 4);
    repeat (150) @(negedge ref_clk_in);
    seq_u.fire(EV_CMD);
    t0 = cyc;
    hold(1, 1'b1, 200, "restarted run");
    wait_lvl(1, 1'b0, 100);
    near("restart time", 2 * 64 * TDIV, cyc - t0);
  endtask : s_zero_restart
  task automatic s_modes();
    wr_reg(ADDR_MODE, 8'h01);
    set_nrt(8'h00, 8'h02, 8'h00);
    seq_u.fire(EV_TX);
    hold(1, 1'b0, 30, "nfc run without field");
    @(posedge ref_clk_in);
    seq_u.ext_field_r <= 1'b1;
    wait_lvl(1, 1'b1, 4);
    chk("nfc run with field", 8'h01, {7'h0, nrt_run});
    stop_nrt();
    @(posedge ref_clk_in);
    seq_u.ext_field_r <= 1'b0;
    // active peer outranks the nfc bit, so no field is needed here
    wr_reg(ADDR_MODE, 8'h03);
    set_nrt(8'h00, 8'h02, 8'h00);
    seq_u.fire(EV_TX);
    wait_lvl(1, 1'b1, 4);
    chk("peer run at tx end", 8'h01, {7'h0, nrt_run});
    stop_nrt();
    set_nrt(8'h00, 8'h02, 8'h04);
    seq_u.fire(EV_TX);
    hold(1, 1'b0, 30, "peer run before field");
    seq_u.fire(EV_PEER);
    wait_lvl(1, 1'b1, 4);
    chk("peer run at field on", 8'h01, {7'h0, nrt_run});
    stop_nrt();
    wr_reg(ADDR_MODE, 8'h00);
  endtask : s_modes
  task automatic s_resp();
    logic [7:0] d;
    wait_lvl(0, 1'b0, 2000);
    wr_reg(ADDR_IRQ_ST, 8'h07);
    set_nrt(8'h00, 8'h02, 8'h00);
    seq_u.fire(EV_CMD);
    wait_lvl(1, 1'b1, 4);
    repeat (20) @(negedge ref_clk_in);
    seq_u.fire(EV_RESP);
    wait_lvl(1, 1'b0, 4);
    repeat (300) @(negedge ref_clk_in);
    rd_reg(ADDR_IRQ_ST, d);
    chk("no timeout after response", 8'h00, d & 8'h01);
  endtask : s_resp
  task automatic s_corr();
    int t0;
    logic [7:0] d;
    wr_reg(ADDR_CORR, 8'h01);
    // the copy on the pin lags the register by one cycle
    repeat (2) @(negedge ref_clk_in);
    chk("stream select", 8'h01, {6'h0, rel_sel, subc});
    @(posedge ref_clk_in);
    seq_u.corr_en_r <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      wait_lvl(2, 1'b1, 40);
      t0 = cyc;
      wait_lvl(2, 1'b0, RLG + 10);
      near("timed wake", (i == 0) ? RSH : RLG, cyc - t0);
      wr_reg(ADDR_MODE, 8'h04);
    end
    wr_reg(ADDR_CORR, 8'h02);
    wait_lvl(2, 1'b1, 40);
    chk("release select", 8'h02, {6'h0, rel_sel, subc});
    rd_reg(ADDR_IRQ_ST, d);
    chk("sleep status", 8'h04, d & 8'h04);
    hold(2, 1'b1, 100, "sleep held");
    @(posedge ref_clk_in);
    seq_u.rx_on_r <= 1'b1;
    wait_lvl(2, 1'b0, 4);
    chk("wake on receiver", 8'h00, {7'h0, corr_sleep});
  endtask : s_corr
  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    s_reset();
    s_mask(8'h00, 8'h02, 2 * 64 * TDIV);
    s_mask(8'h08, 8'h01, 512 * TDIV);
    s_nrt(8'h01, 8'h01, 8'h00, 257 * 64 * TDIV);
    s_irq();
    s_nrt(8'h00, 8'h01, 8'h01, 4096 * TDIV);
    s_zero_restart();
    s_modes();
    s_resp();
    s_corr();
    give_verdict();
  end
endmodule : rx_mask_and_response_timers_bench
